/* File: rtl/tlic_controller.v */
// Two-level interrupt controller with an Avalon-MM register slave.
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tlic_defines.vh"
// Summary of operation
// - Nine flags feed seven channels, each with an enable, priority bit and vector.
// - Each external pin is falling-edge or low-level triggered by a bit.
// - Edge mode samples each pin once per machine cycle, high then low.
// - Edge mode clears the pin flag when its routine is vectored to.
// - Level mode keeps the flag on vectoring; a held low pin re-requests.
// - Timer a and b overflow flags request and clear on service.
// - Timer c requests on overflow OR external flag; software clears both.
// - Watchdog timeout sets its flag; it interrupts only with its enable.
// - Every interrupt flag is writable so software can raise requests.
// - A source passes only if enabled; global enable off blocks all.
// - Each source is high or low priority; low never preempts high.
// - Equal priority requests are served in the fixed channel order.
// - Fixed vectors per channel; serial requests on receive OR transmit.
module tlic_controller
#(
   parameter MC_CYCLES = `TLIC_MC_CYCLES
)
(
   input  wire        clk,
   input  wire        resetn,
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        ext_irq_pin_a,
   input  wire        ext_irq_pin_b,
   input  wire        timer_a_overflow_set,
   input  wire        timer_b_overflow_set,
   input  wire        timer_c_overflow_set,
   input  wire        timer_c_external_set,
   input  wire        serial_receive_set,
   input  wire        serial_transmit_set,
   input  wire        watchdog_timeout,
   input  wire        core_ready,
   input  wire        core_reti,
   output reg         irq_req,
   output reg  [15:0] irq_vector,
   output reg         irq_ack,
   output reg  [1:0]  active_levels,
   output reg  [8:0]  flags_out,
   output reg         irq
);

   localparam NF = 9;
   localparam NC = `TLIC_NCH;
   localparam ST_IDLE = 3'b001;
   localparam ST_ACK  = 3'b010;
   localparam ST_WAIT = 3'b100;

   reg  [NF-1:0]  flags;
   reg  [NC-1:0]  enable;
   reg  [NC-1:0]  prio;
   reg  [`TLIC_C_WIDTH-1:0] ctrl;
   reg  [1:0]     in_service;
   reg  [2:0]     state;
   reg  [2:0]     win_ch;
   reg  [7:0]     mc_cnt;
   reg            pin_a_smp;
   reg            pin_b_smp;
   reg            bus_busy;

   wire           mc_tick;
   wire           fall_a;
   wire           fall_b;
   wire           wr_hit;
   wire           rd_hit;
   wire [NC-1:0]  raw_req;
   wire [NC-1:0]  gated;
   wire [NC-1:0]  hi_req;
   wire [NC-1:0]  lo_req;
   wire           serve;
   wire           ack_fire;
   reg  [NF-1:0]  next_flags;
   reg  [2:0]     pick;
   reg            pick_hi;
   reg            pick_ok;
   reg  [15:0]    pick_vec;
   reg  [NC-1:0]  hit;
   reg  [31:0]    next_rdata;
   integer        i;

   // Pin sampling and every accept happen on the last clock of a cycle.
   assign mc_tick = (mc_cnt == MC_CYCLES - 1);

   assign fall_a = mc_tick && pin_a_smp && !ext_irq_pin_a;
   assign fall_b = mc_tick && pin_b_smp && !ext_irq_pin_b;

   always @(posedge clk)
   begin
      if (!resetn)
      begin
         mc_cnt    <= 8'h00;
         pin_a_smp <= 1'b1;
         pin_b_smp <= 1'b1;
      end
      else
      begin
         mc_cnt <= mc_tick ? 8'h00 : mc_cnt + 8'h01;
         // relies on one sample per machine cycle.
         if (mc_tick)
         begin
            pin_a_smp <= ext_irq_pin_a;
            pin_b_smp <= ext_irq_pin_b;
         end
      end
   end

   assign raw_req[`TLIC_CH_EXT_A]  = flags[`TLIC_F_EXT_A];
   assign raw_req[`TLIC_CH_TMR_A]  = flags[`TLIC_F_TMR_A];
   assign raw_req[`TLIC_CH_EXT_B]  = flags[`TLIC_F_EXT_B];
   assign raw_req[`TLIC_CH_TMR_B]  = flags[`TLIC_F_TMR_B];
   assign raw_req[`TLIC_CH_SERIAL] = flags[`TLIC_F_RX] | flags[`TLIC_F_TX];
   assign raw_req[`TLIC_CH_TMR_C]  = flags[`TLIC_F_TMR_C_OV]
                                   | flags[`TLIC_F_TMR_C_EX];
   // watchdog request, gated by its own enable bit below
   assign raw_req[`TLIC_CH_WDOG]   = flags[`TLIC_F_WDOG];

   assign gated  = ctrl[`TLIC_C_GLOBAL] ? (raw_req & enable) : {NC{1'b0}};
   assign hi_req = gated & prio;
   assign lo_req = gated & ~prio;

   always @*
   begin
      pick    = 3'd0;
      pick_hi = 1'b0;
      pick_ok = 1'b0;
      hit     = (|hi_req) ? hi_req : lo_req;
      for (i = NC - 1; i >= 0; i = i - 1)
      begin
         if (hit[i])
            pick = i[2:0];
      end
      if (|hi_req)
      begin
         pick_hi = 1'b1;
         pick_ok = !in_service[1];
      end
      else if (|lo_req)
         pick_ok = (in_service == 2'b00);
   end

   always @*
   begin
      case (pick)
         3'd0:    pick_vec = `TLIC_VEC_EXT_A;
         3'd1:    pick_vec = `TLIC_VEC_TMR_A;
         3'd2:    pick_vec = `TLIC_VEC_EXT_B;
         3'd3:    pick_vec = `TLIC_VEC_TMR_B;
         3'd4:    pick_vec = `TLIC_VEC_SERIAL;
         3'd5:    pick_vec = `TLIC_VEC_TMR_C;
         default: pick_vec = `TLIC_VEC_WDOG;
      endcase
   end

   assign serve    = (state == ST_IDLE) && pick_ok && mc_tick;
   assign ack_fire = (state == ST_ACK) && core_ready;

   // A write lands only at the edge where waitrequest is low, so a master
   // that is still waiting never sees its write take effect early.
   assign wr_hit = avs_write && bus_busy;
   // Read data is captured one edge early so that it stands at the edge
   // where waitrequest is low.
   assign rd_hit = avs_read && !bus_busy;

   always @*
   begin
      next_flags = flags;
      // software write of flags; every bit takes the written value directly
      if (wr_hit && avs_address == `TLIC_OFF_FLAGS && avs_byteenable[0])
      begin
         next_flags[7:0] = avs_writedata[7:0];
      end
      if (wr_hit && avs_address == `TLIC_OFF_FLAGS && avs_byteenable[1])
         next_flags[8] = avs_writedata[8];
      if (ack_fire)
      begin
         if (win_ch == `TLIC_CH_EXT_A && ctrl[`TLIC_C_TRIG_A])
            next_flags[`TLIC_F_EXT_A] = 1'b0;
         if (win_ch == `TLIC_CH_EXT_B && ctrl[`TLIC_C_TRIG_B])
            next_flags[`TLIC_F_EXT_B] = 1'b0;
         if (win_ch == `TLIC_CH_TMR_A)
            next_flags[`TLIC_F_TMR_A] = 1'b0;
         if (win_ch == `TLIC_CH_TMR_B)
            next_flags[`TLIC_F_TMR_B] = 1'b0;
      end
      // trigger type; level mode follows the sampled pin.
      if (ctrl[`TLIC_C_TRIG_A])
      begin
         if (fall_a)
            next_flags[`TLIC_F_EXT_A] = 1'b1;
      end
      else if (mc_tick)
         next_flags[`TLIC_F_EXT_A] = !ext_irq_pin_a;
      if (ctrl[`TLIC_C_TRIG_B])
      begin
         if (fall_b)
            next_flags[`TLIC_F_EXT_B] = 1'b1;
      end
      else if (mc_tick)
         next_flags[`TLIC_F_EXT_B] = !ext_irq_pin_b;
      // Hardware sets win over any clear in the same cycle.
      if (timer_a_overflow_set)
         next_flags[`TLIC_F_TMR_A] = 1'b1;
      if (timer_b_overflow_set)
         next_flags[`TLIC_F_TMR_B] = 1'b1;
      if (serial_receive_set)
         next_flags[`TLIC_F_RX] = 1'b1;
      if (serial_transmit_set)
         next_flags[`TLIC_F_TX] = 1'b1;
      if (timer_c_overflow_set)
         next_flags[`TLIC_F_TMR_C_OV] = 1'b1;
      if (timer_c_external_set)
         next_flags[`TLIC_F_TMR_C_EX] = 1'b1;
      if (watchdog_timeout)
         next_flags[`TLIC_F_WDOG] = 1'b1;
   end

   always @*
   begin
      case (avs_address)
         `TLIC_OFF_FLAGS:  next_rdata = {23'h0, flags};
         `TLIC_OFF_ENABLE: next_rdata = {25'h0, enable};
         `TLIC_OFF_PRIO:   next_rdata = {25'h0, prio};
         `TLIC_OFF_CTRL:   next_rdata = {26'h0, in_service, 4'h0} |
                                        {28'h0, ctrl};
         default:          next_rdata = 32'h0;
      endcase
   end

   always @(posedge clk)
   begin
      if (!resetn)
      begin
         flags           <= 9'h000;
         enable          <= 7'h00;
         prio            <= 7'h00;
         ctrl            <= 4'h0;
         bus_busy        <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end
      else
      begin
         flags <= next_flags;
         // One wait cycle, then waitrequest drops for the taking edge.
         bus_busy        <= (avs_read | avs_write) && !bus_busy;
         avs_waitrequest <= !((avs_read | avs_write) && !bus_busy);
         if (rd_hit)
            avs_readdata <= next_rdata;
         if (wr_hit && avs_byteenable[0])
         begin
            case (avs_address)
               `TLIC_OFF_ENABLE: enable <= avs_writedata[6:0];
               `TLIC_OFF_PRIO:   prio   <= avs_writedata[6:0];
               `TLIC_OFF_CTRL:   ctrl   <= avs_writedata[3:0];
               default:          ;
            endcase
         end
      end
   end

   always @(posedge clk)
   begin
      if (!resetn)
      begin
         state         <= ST_IDLE;
         win_ch        <= 3'd0;
         in_service    <= 2'b00;
         irq_req       <= 1'b0;
         irq_ack       <= 1'b0;
         irq_vector    <= 16'h0000;
         active_levels <= 2'b00;
         flags_out     <= 9'h000;
         irq           <= 1'b0;
      end
      else
      begin
         irq_ack   <= 1'b0;
         flags_out <= next_flags;
         irq       <= |gated;
         case (state)
            ST_IDLE:
               if (serve)
               begin
                  win_ch     <= pick;
                  irq_vector <= pick_vec;
                  irq_req    <= 1'b1;
                  state      <= ST_ACK;
               end
            ST_ACK:
               if (core_ready)
               begin
                  irq_req <= 1'b0;
                  irq_ack <= 1'b1;
                  state   <= ST_WAIT;
               end
            ST_WAIT:
               // Lets the flag clear settle before a new pick.
               state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
         // level tracking
         // A return is honoured in every state and ahead of an accept in the
         // same cycle, so a return that meets an accept is never lost.
         if (core_reti)
         begin
            if (in_service[1])
               in_service[1] <= 1'b0;
            else
               in_service[0] <= 1'b0;
         end
         if (serve)
         begin
            if (pick_hi)
               in_service[1] <= 1'b1;
            else
               in_service[0] <= 1'b1;
         end
         active_levels <= in_service;
      end
   end

endmodule // tlic_controller
`default_nettype wire

/* File: rtl/tlic_defines.vh */
// Constants shared by the two-level interrupt controller.
`ifndef TLIC_DEFINES_VH
`define TLIC_DEFINES_VH
`define TLIC_NSRC        11
`define TLIC_NCH         7
`define TLIC_VEC_W       16
`define TLIC_VEC_EXT_A   16'h0003
`define TLIC_VEC_TMR_A   16'h000B
`define TLIC_VEC_EXT_B   16'h0013
`define TLIC_VEC_TMR_B   16'h001B
`define TLIC_VEC_SERIAL  16'h0023
`define TLIC_VEC_TMR_C   16'h002B
`define TLIC_VEC_WDOG    16'h0063
`define TLIC_MC_CYCLES   4
// Register byte offsets on the bus.
`define TLIC_OFF_FLAGS   4'h0
`define TLIC_OFF_ENABLE  4'h4
`define TLIC_OFF_PRIO    4'h8
`define TLIC_OFF_CTRL    4'hC
// Flag bit positions.
`define TLIC_F_EXT_A     0
`define TLIC_F_TMR_A     1
`define TLIC_F_EXT_B     2
`define TLIC_F_TMR_B     3
`define TLIC_F_RX        4
`define TLIC_F_TX        5
`define TLIC_F_TMR_C_OV  6
`define TLIC_F_TMR_C_EX  7
`define TLIC_F_WDOG      8
// Control register bits.
`define TLIC_C_GLOBAL    0
`define TLIC_C_TRIG_A    1
`define TLIC_C_TRIG_B    2
`define TLIC_C_WDOG_EN   3
`define TLIC_C_WIDTH     4
// Channel order, highest natural priority first.
`define TLIC_CH_EXT_A    0
`define TLIC_CH_TMR_A    1
`define TLIC_CH_EXT_B    2
`define TLIC_CH_TMR_B    3
`define TLIC_CH_SERIAL   4
`define TLIC_CH_TMR_C    5
`define TLIC_CH_WDOG     6
`endif

/* File: verification/tlic_monitor.sv */
// Port checker for the two-level interrupt controller.
`timescale 1ns/100ps
`default_nettype none
module tlic_monitor
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        core_ready,
   input wire logic        irq_req,
   input wire logic [15:0] irq_vector,
   input wire logic        irq_ack,
   input wire logic [1:0]  active_levels,
   input wire logic [8:0]  flags_out,
   input wire logic        irq,
   input wire logic        timer_a_overflow_set,
   input wire logic        watchdog_timeout
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   property p_ack;
      irq_ack |-> $past(irq_req && core_ready);
   endproperty
   a_ack: assert property (p_ack) else $error("stray ack");
   property p_hold;
      irq_req && !core_ready |=> irq_req && $stable(irq_vector);
   endproperty
   a_hold: assert property (p_hold) else $error("vector dropped");
   property p_drop;
      irq_ack |-> !irq_req && active_levels != 2'h0;
   endproperty
   a_drop: assert property (p_drop) else $error("no level");
   property p_vec;
      irq_req |-> irq_vector inside {16'h0003, 16'h000B, 16'h0013,
         16'h001B, 16'h0023, 16'h002B, 16'h0063};
   endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_irq;
      irq |-> (flags_out | $past(flags_out)) != 9'h000;
   endproperty
   a_irq: assert property (p_irq) else $error("irq no flag");
   property p_tmr;
      timer_a_overflow_set |=> flags_out[1];
   endproperty
   a_tmr: assert property (p_tmr) else $error("tmr flag");
   property p_wdog;
      watchdog_timeout |=> flags_out[8];
   endproperty
   a_wdog: assert property (p_wdog) else $error("wdog flag");
   property p_tck;
      irq_ack && $past(irq_vector) == 16'h002B |-> flags_out[7:6] != 2'h0;
   endproperty
   a_tck: assert property (p_tck) else $error("tmr c cleared");
   c_hi: cover property (irq_ack && active_levels[1]);
   c_lo: cover property (irq_ack && active_levels[0]);
   c_wait: cover property ((irq_req && !core_ready) [*3]);
endmodule // tlic_monitor
`default_nettype wire

/* File: verification/tlic_core_model.sv */
// Behavioural core that takes vectors and returns from routines.
`timescale 1ns/100ps
`default_nettype none
module tlic_core_model
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       irq_req,
   input  wire logic       irq_ack,
   input  wire logic [3:0] ready_dly,
   output var  logic       core_ready,
   output var  logic       core_reti
);
   initial
   begin
      core_ready = 1'b0;
      core_reti  = 1'b0;
      forever
      begin
         @(posedge clk);
         if (irq_req === 1'b1 && resetn === 1'b1)
         begin
            repeat (ready_dly) @(posedge clk);
            core_ready <= 1'b1;
            do @(posedge clk); while (irq_ack !== 1'b1);
            core_ready <= 1'b0;
            repeat (8) @(posedge clk);
            core_reti <= 1'b1;
            @(posedge clk);
            core_reti <= 1'b0;
         end
      end
   end
endmodule // tlic_core_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the two-level interrupt controller.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam logic W = 1'b1, R = 1'b0;
   logic        clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0;
   logic        pin_a = 1'b1, pin_b = 1'b1;
   logic [3:0]  adr = 4'h0, dly = 4'h1;
   logic [31:0] wdat = 32'h0, got;
   logic [6:0]  sets = 7'h00;
   wire  [31:0] rdat;
   wire  [15:0] irq_vector;
   wire  [8:0]  flags_out;
   wire  [1:0]  active_levels;
   wire         wreq, core_ready, core_reti, irq_req, irq_ack, irq;
   int          num_errors, comparisons, i;
   tlic_controller #(.MC_CYCLES(4)) dut (.clk, .resetn,
      .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdat), .avs_byteenable(4'hF),
      .avs_readdata(rdat), .avs_waitrequest(wreq),
      .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
      .timer_a_overflow_set(sets[0]), .timer_b_overflow_set(sets[1]),
      .timer_c_overflow_set(sets[2]), .timer_c_external_set(sets[3]),
      .serial_receive_set(sets[4]), .serial_transmit_set(sets[5]),
      .watchdog_timeout(sets[6]), .core_ready, .core_reti, .irq_req,
      .irq_vector, .irq_ack, .active_levels, .flags_out, .irq);
   tlic_core_model core (.clk, .resetn, .irq_req, .irq_ack,
      .ready_dly(dly), .core_ready, .core_reti);
   initial
      forever #2.5 clk = ~clk;
   task automatic cmp(input logic [31:0] e, input logic [31:0] a);
      comparisons++;
      if (a !== e)
      begin
         num_errors++;
         $display("unexpected at %0t exp %h got %h", $time, e, a);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      adr  <= a;
      wdat <= d;
      wr   <= w;
      rd   <= ~w;
      do @(posedge clk); while (wreq !== 1'b0);
      got = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic srv(input logic [15:0] v);
      for (i = 0; i < 300 && irq_req !== 1'b1; i++) @(posedge clk);
      cmp(32'h1, irq_req);
      cmp(v, irq_vector);
      cmp(32'h1, irq);
      for (i = 0; i < 300 && irq_ack !== 1'b1; i++) @(posedge clk);
      cmp(32'h1, irq_ack);
      @(posedge clk);
   endtask
   task automatic pulse(input logic [6:0] m);
      @(posedge clk);
      sets <= m;
      @(posedge clk);
      sets <= 7'h00;
   endtask
   task automatic t_reset;
      bus(R, 4'hC, 32'h0);
      cmp(32'h0, got);
      bus(R, 4'h2, 32'h0);
      cmp(32'h0, got);
   endtask
   task automatic t_order;
      bus(W, 4'hC, 32'h7);
      bus(W, 4'h4, 32'h7F);
      bus(R, 4'h4, 32'h0);
      cmp(32'h7F, got);
      bus(W, 4'h0, 32'h0F);
      srv(16'h0003);
      srv(16'h000B);
      srv(16'h0013);
      srv(16'h001B);
      cmp(32'h0, flags_out);
      bus(W, 4'h0, 32'h150);
      srv(16'h0023);
      bus(W, 4'h0, 32'h140);
      srv(16'h002B);
      bus(W, 4'h0, 32'h100);
      srv(16'h0063);
      bus(W, 4'h0, 32'h0);
   endtask
   task automatic t_gate;
      bus(W, 4'h4, 32'h3F);
      pulse(7'h40);
      repeat (12) @(posedge clk);
      cmp(32'h1, flags_out[8]);
      cmp(32'h0, irq);
      bus(W, 4'hC, 32'h6);
      bus(W, 4'h0, 32'h102);
      repeat (12) @(posedge clk);
      cmp(32'h0, irq_req);
      cmp(32'h0, irq);
      bus(W, 4'hC, 32'h7);
      srv(16'h000B);
      bus(W, 4'h0, 32'h0);
   endtask
   task automatic t_hw;
      dly <= 4'h6;
      bus(W, 4'h8, 32'h20);
      pulse(7'h0D);
      srv(16'h002B);
      cmp(32'h3, flags_out[7:6]);
      cmp(32'h2, active_levels);
      bus(W, 4'h0, 32'h2);
      srv(16'h000B);
      cmp(32'h0, flags_out[1]);
      pulse(7'h32);
      srv(16'h001B);
      srv(16'h0023);
      bus(W, 4'h0, 32'h0);
      bus(W, 4'h8, 32'h0);
      dly <= 4'h1;
   endtask
   task automatic t_edge;
      pin_b <= 1'b0;
      srv(16'h0013);
      cmp(32'h0, flags_out[2]);
      repeat (24) @(posedge clk);
      cmp(32'h0, irq_req);
      pin_b <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   task automatic t_level;
      bus(W, 4'hC, 32'h5);
      pin_a <= 1'b0;
      srv(16'h0003);
      cmp(32'h1, flags_out[0]);
      bus(R, 4'hC, 32'h0);
      cmp(32'h15, got);
      cmp(32'h1, active_levels);
      srv(16'h0003);
      bus(W, 4'h4, 32'h7E);
      pin_a <= 1'b1;
      repeat (12) @(posedge clk);
      cmp(32'h0, flags_out[0]);
   endtask
   task automatic print_verdict;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_order;
      t_gate;
      t_hw;
      t_edge;
      t_level;
      print_verdict;
   end
   initial
   begin
      #60000;
      num_errors++;
      print_verdict;
   end
endmodule // testbench
bind tlic_controller tlic_monitor mon (.clk, .resetn, .core_ready,
   .irq_req, .irq_vector, .irq_ack, .active_levels, .flags_out, .irq,
   .timer_a_overflow_set, .watchdog_timeout);
`default_nettype wire
